// *** inc/mpoc_pkg.sv ***
// constants and carrier types for the motor pwm output configuration block
package mpoc_pkg;

	// register map (chosen offsets)
	localparam logic [3:0] ADDR_MODE_A   = 4'h0;
	localparam logic [3:0] ADDR_FEEDBACK = 4'h1;
	localparam logic [3:0] ADDR_PARITY   = 4'h2;
	localparam logic [3:0] ADDR_PHASE    = 4'h3;
	localparam logic [3:0] ADDR_DEADTIME = 4'h4;
	localparam logic [3:0] ADDR_CTRL     = 4'h5;
	localparam logic [3:0] ADDR_WEIGHT   = 4'h6;
	localparam logic [3:0] ADDR_ZPREV    = 4'h7;
	localparam logic [3:0] ADDR_ZCUR     = 4'h8;
	localparam logic [3:0] ADDR_DELAY    = 4'h9;
	localparam logic [3:0] ADDR_STATUS   = 4'ha;
	localparam logic [3:0] ADDR_PAGE1    = 4'hf;

	// mode_a fields
	localparam int BIT_SENSOR   = 5;
	localparam int BIT_DIRECT   = 4;
	localparam int BIT_CURRENT  = 3;
	localparam int BIT_AUTOSW   = 2;
	localparam int BIT_ZGUARD   = 1;
	localparam int BIT_CAPSEL   = 0;
	// feedback fields
	localparam int BIT_PAGE     = 7;
	localparam int BIT_PRST     = 6;
	localparam int CFF_LSB      = 3;
	localparam int CFW_LSB      = 0;
	// deadtime register fields
	localparam int BIT_THREEPH  = 7;
	localparam int BIT_DTE      = 6;
	// ctrl register fields
	localparam int BIT_CLKEN    = 0;
	localparam int BIT_OUTEN    = 1;

	// reset values
	localparam logic [7:0] RST_MODE_A   = 8'h00;
	localparam logic [7:0] RST_FEEDBACK = 8'h00;
	localparam logic [7:0] RST_PARITY   = 8'h00;
	localparam logic [7:0] RST_DEADTIME = 8'hff;
	localparam logic [5:0] RST_OUT_LVL  = 6'h00;

	// timing
	localparam int PERIPH_HZ     = 4_000_000;
	localparam int CLK_HZ        = 100_000_000;
	localparam int SAMPLE_DIV    = 4;
	localparam int BLANK_STEP_NS = 500;
	localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * (PERIPH_HZ / 1_000_000)) / 1000;
	localparam int PWM_BITS      = 12;

	// register set
	typedef struct packed {
		logic [7:0] mode_a;
		logic [7:0] feedback;
		logic [7:0] parity;
		logic [7:0] phase_act;
		logic [7:0] phase_pre;
		logic [7:0] deadtime;
		logic [7:0] ctrl;
		logic [7:0] weight;
		logic [7:0] zprev;
		logic [7:0] zcur;
		logic [7:0] delay;
	} mpoc_regs_t;

	// whole block state
	typedef struct packed {
		mpoc_regs_t        r;
		logic [PWM_BITS-1:0] pwm_cnt;
		logic [1:0]        div;
		logic [2:0]        filt_cnt;
		logic [3:0]        blank_cnt;
		logic              pwm_d;
		logic              cur_limit;
		logic              comm_evt;
		logic              wait_comm;
		logic [1:0]        tacho_d;
		logic              tacho_evt;
		logic [7:0]        rdata;
		logic [5:0]        out;
		logic [1:0]        cur_s;
		logic [1:0]        tach_s;
		logic [1:0]        comm_s;
	} mpoc_state_t;

endpackage

// *** rtl/mpoc_top.sv ***
// motor pwm output configuration: mode registers, dead-time pairing, current filter
`timescale 1ns/1ns

// What this block does
// RQ1 - six-step from one pwm source when
// RQ2 - dead-time groups outputs in pairs 0/1,2/3,4/5
// RQ3 - both active with pwm forces pair low
// RQ4 - no pwm: 10->10, 01->01, 00->00
// RQ5 - software clears three-phase before dead-time enable
// RQ6 - pwm counter held reset while clock off
// RQ7 - clock enable copies preload to active
// RQ8 - sensor select bit 5; sensor ignores side bit
// RQ9 - no direct access: preload applied at commutation
// RQ10 - direct access: phase write makes commutation
// RQ11 - outputs reset, normal, or phase register
// RQ12 - bit3 voltage/current, bit2 switched/autoswitched
// RQ13 - reset sets the commutation wait; mode_a resets to switched, so it clears a cycle later
// RQ14 - clock and autoswitch together with zero delay: instant commutation
// RQ15 - zero guard ignores zero event filter
// RQ16 - delay is weight times capture over 256
// RQ17 - page select bit 7 chooses page
// RQ18 - peripheral reset bit returns all registers to reset values (deadtime to ff, others cleared)
// RQ19 - limit needs filter plus one samples
// RQ20 - blanking window after pwm turn-on
// RQ21 - tacho edge field selects capture edges
// RQ22 - parity bits pick side, off in three-phase
// RQ23 - same-label pair gives complementary pwm
// RQ24 - blanking counted two peripheral cycles per step
module mpoc_top
	import mpoc_pkg::*;
(
	input  wire logic       i_ref_clk,    // peripheral clock
	input  wire logic       i_rst_b,      // async reset, active low
	input  wire logic [3:0] i_addr,       // register address
	input  wire logic [7:0] i_wdata,      // write data
	input  wire logic       i_wr,         // write strobe
	input  wire logic       i_rd,         // read strobe
	output logic      [7:0] o_rdata,      // read data, cycle after strobe
	input  wire logic       i_pwm_u,      // u compare pwm (voltage source)
	input  wire logic       i_meas_win,   // measurement window (current source)
	input  wire logic       i_cur_cmp,    // current comparator pin
	input  wire logic       i_tacho,      // tacho pin
	input  wire logic       i_comm_evt,   // commutation event from sequencer
	input  wire logic [5:0] i_three_ph,   // three-phase drive levels
	output logic      [5:0] o_motor_out,  // motor output pins
	output logic            o_cur_limit,  // filtered current-limit level
	output logic            o_tacho_evt,  // speed capture pulse
	output logic            o_comm,       // commutation event pulse
	output logic [PWM_BITS-1:0] o_pwm_cnt // pwm counter
);

	mpoc_state_t s;
	mpoc_state_t next_s;

	// pair output shaping for one pair
	function automatic logic [1:0] pair_out(input logic [1:0] on, input logic [1:0] side,
		input logic pwm_side, input logic pwm);
		logic a;
		logic b;
		a = on[0] && (side[0] == pwm_side);
		b = on[1] && (side[1] == pwm_side);
		pair_out = 2'b00;
		if (on == 2'b11 && (a || b)) begin
			pair_out = 2'b00;                          // [RQ3]
		end else if (on[0] && a) begin
			pair_out = {~pwm, pwm};                    // [RQ23]
		end else if (on[1] && b) begin
			pair_out = {pwm, ~pwm};                    // [RQ23]
		end else if (on == 2'b01 || on == 2'b10) begin
			pair_out = on;                             // [RQ4]
		end
	endfunction

	logic [5:0]  six;
	logic        src_pwm;
	logic        pwm_side;
	logic [15:0] product;
	logic        clk_rise;
	logic        we;

	// combinational next state
	always_comb begin
		next_s = s;
		next_s.comm_evt = 1'b0;
		next_s.tacho_evt = 1'b0;
		product = 16'h0000;
		six = 6'h00;
		we = i_wr && !s.r.feedback[BIT_PAGE];          // [RQ17]
		// input synchronisers
		next_s.cur_s  = {s.cur_s[0], i_cur_cmp};
		next_s.tach_s = {s.tach_s[0], i_tacho};
		next_s.comm_s = {s.comm_s[0], i_comm_evt};

		// register writes
		clk_rise = 1'b0;
		if (we) begin
			case (i_addr)
				ADDR_MODE_A:   next_s.r.mode_a = i_wdata;
				ADDR_FEEDBACK: next_s.r.feedback = i_wdata;
				ADDR_PARITY:   next_s.r.parity = i_wdata;
				ADDR_PHASE: begin
					next_s.r.phase_pre = {2'b00, i_wdata[5:0]};
					if (s.r.mode_a[BIT_DIRECT]) begin
						next_s.r.phase_act = {2'b00, i_wdata[5:0]};
						next_s.comm_evt = 1'b1;        // [RQ10]
					end
				end
				ADDR_DEADTIME: next_s.r.deadtime = i_wdata;
				ADDR_CTRL: begin
					next_s.r.ctrl = i_wdata;
					clk_rise = i_wdata[BIT_CLKEN] && !s.r.ctrl[BIT_CLKEN];
				end
				ADDR_WEIGHT:   next_s.r.weight = i_wdata;
				ADDR_ZPREV:    next_s.r.zprev = i_wdata;
				ADDR_ZCUR:     next_s.r.zcur = i_wdata;
				default: ;
			endcase
		end
		if (i_wr && s.r.feedback[BIT_PAGE] && i_addr == ADDR_PAGE1) begin
			next_s.r.feedback = i_wdata;               // [RQ17] feedback reachable on both pages
		end

		// commutation delay from selected capture
		product = s.r.weight * (s.r.mode_a[BIT_CAPSEL] ? s.r.zcur : s.r.zprev);
		next_s.r.delay = product[15:8];                // [RQ16]

		// clock enable loads preloads; autoswitch with nil delay commutes now
		if (clk_rise) begin
			next_s.r.phase_act = s.r.phase_pre;        // [RQ7]
			if (next_s.r.mode_a[BIT_AUTOSW] && s.r.delay == 8'h00) begin
				next_s.comm_evt = 1'b1;                // [RQ14]
			end
		end

		// external commutation event applies preload
		if (s.comm_s[1] && !s.r.mode_a[BIT_DIRECT]) begin
			next_s.r.phase_act = s.r.phase_pre;        // [RQ9]
			next_s.comm_evt = 1'b1;
		end
		if (next_s.comm_evt) begin
			next_s.wait_comm = 1'b0;
		end else if (!s.r.mode_a[BIT_AUTOSW]) begin
			next_s.wait_comm = 1'b0;                   // [RQ13] only autoswitched mode waits
		end

		// pwm counter held while clock off
		if (!s.r.ctrl[BIT_CLKEN]) begin
			next_s.pwm_cnt = '0;                       // [RQ6]
		end else begin
			next_s.pwm_cnt = s.pwm_cnt + 1'b1;
		end

		// pwm source: u pair or measurement window
		src_pwm = s.r.mode_a[BIT_CURRENT] ? i_meas_win : i_pwm_u;   // [RQ1] [RQ12]
		// sensor mode uses only the lowest side bit
		pwm_side = s.r.mode_a[BIT_SENSOR] ? s.r.ctrl[2] : s.r.ctrl[3];   // [RQ8] [RQ22]

		// blanking after pwm turn-on
		next_s.pwm_d = src_pwm;
		if (src_pwm && !s.pwm_d && s.r.feedback[2:0] != 3'h0) begin
			next_s.blank_cnt = 4'(s.r.feedback[2:0] * BLANK_STEP_CYC);   // [RQ20] [RQ24]
		end else if (s.blank_cnt != 4'h0) begin
			next_s.blank_cnt = s.blank_cnt - 4'h1;
		end

		// current-limit filter at quarter rate
		next_s.div = s.div + 2'h1;
		if (s.div == 2'(SAMPLE_DIV - 1)) begin
			if (s.cur_s[1] && s.blank_cnt == 4'h0) begin
				if (s.filt_cnt == s.r.feedback[5:3]) begin
					next_s.cur_limit = 1'b1;           // [RQ19]
				end else begin
					next_s.filt_cnt = s.filt_cnt + 3'h1;
				end
			end else begin
				next_s.filt_cnt = 3'h0;
				next_s.cur_limit = 1'b0;
			end
		end

		// tacho edge capture
		next_s.tacho_d = {s.tacho_d[0], s.tach_s[1]};
		case (s.r.parity[7:6])
			2'b01:   next_s.tacho_evt = s.tacho_d[0] && !s.tacho_d[1];   // [RQ21]
			2'b10:   next_s.tacho_evt = !s.tacho_d[0] && s.tacho_d[1];
			2'b11:   next_s.tacho_evt = s.tacho_d[0] ^ s.tacho_d[1];
			default: next_s.tacho_evt = 1'b0;
		endcase

		// six-step outputs, paired when dead-time on
		for (int p = 0; p < 3; p++) begin
			if (s.r.deadtime[BIT_DTE]) begin
				six[2*p +: 2] = pair_out(s.r.phase_act[2*p +: 2],
					s.r.parity[2*p +: 2], pwm_side, src_pwm);   // [RQ2] [RQ22]
			end else begin
				for (int k = 0; k < 2; k++) begin
					six[2*p+k] = s.r.phase_act[2*p+k] &&
						((s.r.parity[2*p+k] == pwm_side) ? src_pwm : 1'b1);
				end
			end
		end
		if (!s.r.ctrl[BIT_OUTEN]) begin
			next_s.out = RST_OUT_LVL;                  // [RQ11]
		end else if (s.r.deadtime[BIT_THREEPH]) begin
			next_s.out = i_three_ph;                   // [RQ22] parity ignored
		end else if (s.wait_comm) begin
			next_s.out = 6'h00;                        // [RQ13]
		end else begin
			next_s.out = six;                          // [RQ11]
		end

		// zero guard overrides zero filter in status
		next_s.rdata = 8'h00;
		if (i_rd) begin
			// page 1 maps only the feedback register; other addresses read zero
			case ((s.r.feedback[BIT_PAGE] && i_addr != ADDR_PAGE1) ? ADDR_STATUS + 4'h1 : i_addr)
				ADDR_MODE_A:   next_s.rdata = s.r.mode_a;
				ADDR_FEEDBACK: next_s.rdata = s.r.feedback;
				ADDR_PARITY:   next_s.rdata = s.r.parity;
				ADDR_PHASE:    next_s.rdata = s.r.phase_act;
				ADDR_DEADTIME: next_s.rdata = s.r.deadtime;
				ADDR_CTRL:     next_s.rdata = s.r.ctrl;
				ADDR_WEIGHT:   next_s.rdata = s.r.weight;
				ADDR_ZPREV:    next_s.rdata = s.r.zprev;
				ADDR_ZCUR:     next_s.rdata = s.r.zcur;
				ADDR_DELAY:    next_s.rdata = s.r.delay;
				ADDR_STATUS:   next_s.rdata = {4'h0, s.r.mode_a[BIT_ZGUARD], s.wait_comm,
					s.cur_limit, s.r.mode_a[BIT_ZGUARD] ? 1'b0 : 1'b1};   // [RQ15]
				ADDR_PAGE1:    next_s.rdata = s.r.feedback;
				default:       next_s.rdata = 8'h00;
			endcase
		end

		// software peripheral reset
		if (((we && i_addr == ADDR_FEEDBACK) || (i_wr && s.r.feedback[BIT_PAGE] && i_addr == ADDR_PAGE1))
			&& i_wdata[BIT_PRST]) begin
			next_s.r = '{mode_a: RST_MODE_A, feedback: RST_FEEDBACK, parity: RST_PARITY,
				deadtime: RST_DEADTIME, default: 8'h00};   // [RQ18]
			next_s.wait_comm = 1'b1;
			next_s.out = RST_OUT_LVL;
		end
	end

	// state register
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s <= '0;
			s.r.deadtime <= RST_DEADTIME;
			s.wait_comm <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from state
	assign o_rdata     = s.rdata;
	assign o_motor_out = s.out;
	assign o_cur_limit = s.cur_limit;
	assign o_tacho_evt = s.tacho_evt;
	assign o_comm      = s.comm_evt;
	assign o_pwm_cnt   = s.pwm_cnt;

endmodule

// *** test/mpoc_chk.sv ***
// port assertions for the motor pwm output block
`timescale 1ns/1ns
module mpoc_chk
	import mpoc_pkg::*;
(
	input wire logic                i_ref_clk,   // clock
	input wire logic                i_rst_b,     // reset
	input wire logic [3:0]          i_addr,      // address
	input wire logic [7:0]          i_wdata,     // data
	input wire logic                i_wr,        // write
	input wire logic                i_cur_cmp,   // comparator
	input wire logic [5:0]          o_motor_out, // outputs
	input wire logic                o_cur_limit, // limit
	input wire logic                o_tacho_evt, // tacho pulse
	input wire logic                o_comm,      // commutation
	input wire logic [PWM_BITS-1:0] o_pwm_cnt    // counter
);
	// ========================================
	// shadow of page, direct, clock and tacho bits
	logic       page_q, direct_q, clken_q, srst, wr0, wfb;
	logic [1:0] tes_q;
	assign wr0  = i_wr && !page_q;
	assign wfb  = i_wr && i_addr == (page_q ? ADDR_PAGE1 : ADDR_FEEDBACK);
	assign srst = wfb && i_wdata[BIT_PRST];
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{page_q, direct_q, clken_q, tes_q} <= 5'h00;
		end else if (srst) begin
			{page_q, direct_q, clken_q, tes_q} <= 5'h00;
		end else begin
			if (wfb) page_q <= i_wdata[BIT_PAGE];
			if (wr0 && i_addr == ADDR_MODE_A) direct_q <= i_wdata[BIT_DIRECT];
			if (wr0 && i_addr == ADDR_CTRL) clken_q <= i_wdata[BIT_CLKEN];
			if (wr0 && i_addr == ADDR_PARITY) tes_q <= i_wdata[7:6];
		end
	end
	// ========================================
	// assertions
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	a_comm_pulse: assert property (o_comm |=> !o_comm) else $error("comm too long");
	a_direct_comm: assert property (wr0 && i_addr == ADDR_PHASE && direct_q |=> o_comm)
		else $error("no comm on phase write");
	a_tacho_pulse: assert property (o_tacho_evt |=> !o_tacho_evt) else $error("tacho too long");
	a_tacho_off: assert property (o_tacho_evt |-> $past(tes_q) != 2'h0) else $error("tacho while off");
	a_clk_off: assert property (!clken_q && !$past(clken_q) |-> o_pwm_cnt == 12'h000)
		else $error("counter runs unclocked");
	a_soft_reset: assert property (srst |=> ##1 (o_motor_out == 6'h00) [*4])
		else $error("outputs live after reset");
	a_limit_cause: assert property ($rose(o_cur_limit) |-> $past(i_cur_cmp, 3)) else $error("limit uncaused");
	a_pair_guard: assert property (!(o_motor_out[0] && o_motor_out[1]) && !(o_motor_out[2] && o_motor_out[3])
		&& !(o_motor_out[4] && o_motor_out[5])) else $error("pair both high");
endmodule
bind mpoc_top mpoc_chk chk_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_cur_cmp(i_cur_cmp), .o_motor_out(o_motor_out), .o_cur_limit(o_cur_limit),
	.o_tacho_evt(o_tacho_evt), .o_comm(o_comm), .o_pwm_cnt(o_pwm_cnt));

// *** test/mpoc_power_stage.sv ***
// power stage model: flags cross conduction in a bridge leg
`timescale 1ns/1ns
module mpoc_power_stage (
	input  wire logic       i_ref_clk,      // clock
	input  wire logic       i_rst_b,        // reset
	input  wire logic [5:0] i_gate,         // gate drives
	output logic            o_shoot_through // sticky fault
);
	// ========================================
	// a leg fails once both of its switches conduct
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_shoot_through <= 1'b0;
		end else if ((i_gate[0] & i_gate[1]) | (i_gate[2] & i_gate[3]) | (i_gate[4] & i_gate[5])) begin
			o_shoot_through <= 1'b1;
		end
	end
endmodule

// *** test/tb_motor_pwm_output_config.sv ***
// self-checking bench for the motor pwm output block
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_motor_pwm_output_config
	import mpoc_pkg::*;
;
	typedef struct packed {logic [3:0] wa; logic [7:0] wd; logic [3:0] ra; logic [7:0] ex;} mpoc_row_t;
	logic                i_ref_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_pwm_u = 1'b0;
	logic                i_cur_cmp = 1'b0, i_tacho = 1'b0, o_cur_limit, o_tacho_evt, o_comm, shoot;
	logic [3:0]          i_addr = 4'h0;
	logic [7:0]          i_wdata = 8'h00, o_rdata;
	logic [5:0]          o_motor_out;
	logic [PWM_BITS-1:0] o_pwm_cnt;
	int                  err_total = 0, check_count = 0, n;
	// register rows: write one address, then read the same or a derived register and compare
	mpoc_row_t rows [10] = '{'{ADDR_PARITY, 8'hc5, ADDR_PARITY, 8'hc5}, '{ADDR_WEIGHT, 8'h80, ADDR_WEIGHT, 8'h80},
		'{ADDR_ZPREV, 8'h40, ADDR_DELAY, 8'h20}, '{ADDR_ZCUR, 8'h10, ADDR_ZCUR, 8'h10},
		'{ADDR_MODE_A, 8'h01, ADDR_DELAY, 8'h08}, '{ADDR_DELAY, 8'hff, ADDR_DELAY, 8'h08},
		'{4'hb, 8'h55, 4'hb, 8'h00}, '{ADDR_MODE_A, 8'h02, ADDR_STATUS, 8'h08},
		'{ADDR_MODE_A, 8'h23, ADDR_MODE_A, 8'h23},
		'{ADDR_FEEDBACK, 8'h2d, ADDR_FEEDBACK, 8'h2d}};
	mpoc_top dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_pwm_u(i_pwm_u), .i_meas_win(1'b0), .i_cur_cmp(i_cur_cmp),
		.i_tacho(i_tacho), .i_comm_evt(1'b0), .i_three_ph(6'h00), .o_motor_out(o_motor_out),
		.o_cur_limit(o_cur_limit), .o_tacho_evt(o_tacho_evt), .o_comm(o_comm), .o_pwm_cnt(o_pwm_cnt));
	mpoc_power_stage stage_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_gate(o_motor_out), .o_shoot_through(shoot));
	// ========================================
	// clock and bus tasks
	always #5 i_ref_clk = ~i_ref_clk;
	task automatic stop_test();
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_ref_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		@(negedge i_ref_clk);
		`CHK(o_rdata, e)
	endtask
	task automatic chk_rst();
		rd(ADDR_MODE_A, RST_MODE_A);
		rd(ADDR_FEEDBACK, RST_FEEDBACK);
		rd(ADDR_PARITY, RST_PARITY);
		rd(ADDR_DEADTIME, RST_DEADTIME);
	endtask
	// bounded wait: 0 comm, 1 tacho, 2 limit
	task automatic wait_hi(input int sel, input int lim);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < lim && hit !== 1'b1; k++) begin
			@(negedge i_ref_clk);
			hit = (sel == 0) ? o_comm : (sel == 1) ? o_tacho_evt : o_cur_limit;
		end
		`CHK(hit, 1'b1)
		if (hit !== 1'b1) stop_test();
	endtask
	task automatic out_is(input logic [5:0] e);
		repeat (4) @(negedge i_ref_clk);
		`CHK(o_motor_out, e)
	endtask
	// ========================================
	// main sequence
	initial begin
		repeat (10) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		chk_rst();
		foreach (rows[k]) begin
			wr(rows[k].wa, rows[k].wd);
			repeat (2) @(posedge i_ref_clk);
			rd(rows[k].ra, rows[k].ex);
		end
		wr(ADDR_FEEDBACK, 8'h80);
		rd(ADDR_MODE_A, 8'h00);
		rd(ADDR_PAGE1, 8'h80);
		wr(ADDR_PAGE1, 8'h00);
		rd(ADDR_MODE_A, 8'h23);
		wr(ADDR_FEEDBACK, 8'h40);
		chk_rst();
		wr(ADDR_MODE_A, 8'h04);
		wr(ADDR_CTRL, 8'h01);
		wait_hi(0, 8);
		wr(ADDR_FEEDBACK, 8'h40);
		wr(ADDR_CTRL, 8'h01);
		wr(ADDR_FEEDBACK, 8'h38);
		i_cur_cmp <= 1'b1;
		repeat (24) @(negedge i_ref_clk);
		`CHK(o_cur_limit, 1'b0)
		wait_hi(2, 24);
		@(posedge i_ref_clk);
		i_cur_cmp <= 1'b0;
		wr(ADDR_PARITY, 8'h40);
		i_tacho <= 1'b1;
		wait_hi(1, 8);
		@(posedge i_ref_clk);
		i_tacho <= 1'b0;
		n = 0;
		repeat (8) begin
			@(negedge i_ref_clk);
			n += int'(o_tacho_evt === 1'b1);
		end
		`CHK(n, 0)
		wr(ADDR_FEEDBACK, 8'h40);
		wr(ADDR_DEADTIME, 8'h40);
		wr(ADDR_MODE_A, 8'h10);
		wr(ADDR_CTRL, 8'h0f);
		wr(ADDR_PHASE, 8'h01);
		out_is(6'h01);
		wr(ADDR_PHASE, 8'h02);
		out_is(6'h02);
		wr(ADDR_PARITY, 8'h02);
		i_pwm_u <= 1'b1;
		wr(ADDR_PHASE, 8'h03);
		out_is(6'h00);
		wr(ADDR_PARITY, 8'h03);
		wr(ADDR_PHASE, 8'h01);
		out_is(6'h01);
		@(posedge i_ref_clk);
		i_pwm_u <= 1'b0;
		out_is(6'h02);
		wr(ADDR_CTRL, 8'h0d);
		out_is(6'h00);
		`CHK(shoot, 1'b0)
		stop_test();
	end
endmodule
